// ===== cst_pkg.sv
package cst_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ          = 64'd20000000;
  localparam int     SAMPLE_TIME_MS  = 5;
  localparam longint SAMPLE_CYCLES   = (CLK_HZ * SAMPLE_TIME_MS) / 1000;
  localparam int     INTERVAL_MIN_S  = 21;
  localparam int     INTERVAL_MAX_S  = 168;
  localparam longint INTERVAL_CYCLES = CLK_HZ * INTERVAL_MIN_S;
  // ------------------------------------------------------------
  // converter and encodings
  // ------------------------------------------------------------
  localparam int     ADC_STEP_UV     = 2500;
  localparam int     ADC_W           = 12;
  localparam int     CNT_W           = 40;
  // trickle ratio strap codes
  localparam logic [1:0] TR_SUPPLY   = 2'h0;
  localparam logic [1:0] TR_OPEN     = 2'h1;
  localparam logic [1:0] TR_REF      = 2'h2;
  localparam logic [1:0] TR_NEG      = 2'h3;
  // trickle divide shift per strap code
  localparam logic [2:0] SH_SUPPLY   = 3'h6;
  localparam logic [2:0] SH_OPEN     = 3'h5;
  localparam logic [2:0] SH_REF      = 3'h4;
  localparam logic [2:0] SH_NEG      = 3'h3;
  typedef enum logic [0:0] {CST_FAST, CST_TRICKLE} cst_chg_t;
  typedef enum logic [2:0] {CST_WAIT1, CST_SAMP1, CST_WAIT2, CST_SAMP2, CST_IDLE} cst_slope_t;
endpackage

// ===== cst_slope.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// two-sample slope detector
// ------------------------------------------------------------
module cst_slope #(
  parameter longint INTERVAL = cst_pkg::INTERVAL_CYCLES,
  parameter longint SAMPLE   = cst_pkg::SAMPLE_CYCLES,
  parameter bit     NEG_MODE = 1'b1
) (
  input  wire logic                     core_clk,   // clock
  input  wire logic                     reset,      // sync reset
  input  wire logic                     run,        // fast charge active
  input  wire logic [cst_pkg::ADC_W-1:0] adc_code,  // converter code, 2.5mV lsb
  input  wire logic [4:0]               cells,      // programmed cell count
  output logic                          trip,       // one-cycle termination pulse
  output logic                          sampling    // conversion in progress
);
  cst_pkg::cst_slope_t st_ff;
  logic [cst_pkg::CNT_W-1:0] cnt_ff;
  logic [cst_pkg::ADC_W-1:0] s1_ff;
  logic [cst_pkg::ADC_W:0]   drop;
  logic                      done;

  assign done = (cnt_ff == cst_pkg::CNT_W'(1));
  assign drop = {1'b0, s1_ff} - {1'b0, adc_code};

  // sequencer: wait, sample, wait, sample, compare
  always_ff @(posedge core_clk)
  begin
    if (reset || !run)
    begin
      st_ff  <= run ? cst_pkg::CST_WAIT1 : cst_pkg::CST_IDLE;
      cnt_ff <= cst_pkg::CNT_W'(INTERVAL);
      trip   <= 1'b0;
      s1_ff  <= '0;
    end
    else
    begin
      trip <= 1'b0;
      if (st_ff == cst_pkg::CST_IDLE)
      begin
        st_ff  <= cst_pkg::CST_WAIT1;
        cnt_ff <= cst_pkg::CNT_W'(INTERVAL);
      end
      else if (done)
      begin
        unique case (st_ff)
          cst_pkg::CST_WAIT1:
          begin
            st_ff  <= cst_pkg::CST_SAMP1;
            cnt_ff <= cst_pkg::CNT_W'(SAMPLE);
          end
          cst_pkg::CST_SAMP1:
          begin
            s1_ff  <= adc_code;
            st_ff  <= cst_pkg::CST_WAIT2;
            cnt_ff <= cst_pkg::CNT_W'(INTERVAL);
          end
          cst_pkg::CST_WAIT2:
          begin
            st_ff  <= cst_pkg::CST_SAMP2;
            cnt_ff <= cst_pkg::CNT_W'(SAMPLE);
          end
          cst_pkg::CST_SAMP2:
          begin
            // compare only this cycle's pair
            if (NEG_MODE)
              trip <= !drop[cst_pkg::ADC_W] && (drop >= {8'h00, cells});
            else
              trip <= (adc_code == s1_ff);
            st_ff  <= cst_pkg::CST_WAIT1;
            cnt_ff <= cst_pkg::CNT_W'(INTERVAL);
          end
          default: st_ff <= cst_pkg::CST_IDLE;
        endcase
      end
      else
        cnt_ff <= cnt_ff - cst_pkg::CNT_W'(1);
    end
  end

  assign sampling = (st_ff == cst_pkg::CST_SAMP1) || (st_ff == cst_pkg::CST_SAMP2);

  property p_trip_after_samp2;
    @(posedge core_clk) disable iff (reset) trip |-> $past(st_ff) == cst_pkg::CST_SAMP2;
  endproperty
  a_trip_after_samp2: assert property (p_trip_after_samp2) else $error("trip without second sample");
endmodule

// ===== cst_top.sv
`timescale 1ns/10ps
// Overview of operation
// - trickle ratio follows the ratio strap
// - voltage cap is cells times limit
// - cut drive on overvoltage or overcurrent
// - regulate battery current regardless of load
// - no battery: hold maximum voltage instead
// - converter step is 2.5mV
// - wait one interval before first sample
// - each sample takes 5ms
// - second sample after interval, then compare
// - repeat two-sample cycles until termination
// - zero-slope variant ends on unchanged voltage
// - negative variant ends on cells-scaled drop
// - only fast and trickle states exist
// - timeout or slope forces trickle always
// - hot ends fast charge, no restart
module cst_top #(
  parameter longint INTERVAL = cst_pkg::INTERVAL_CYCLES,
  parameter longint SAMPLE   = cst_pkg::SAMPLE_CYCLES,
  parameter bit     NEG_MODE = 1'b1
) (
  input  wire logic                      core_clk,             // 20 MHz clock
  input  wire logic                      reset,                // sync reset, high
  input  wire logic [1:0]                trickle_ratio_select, // ratio strap code
  input  wire logic                      cell_count_select_lo, // cell count strap lo
  input  wire logic                      cell_count_select_hi, // cell count strap hi
  input  wire logic [4:0]                cell_count,           // decoded cell count
  input  wire logic [cst_pkg::ADC_W-1:0] cell_voltage_limit,   // limit code, 2.5mV lsb
  input  wire logic [cst_pkg::ADC_W-1:0] battery_positive_code,            // battery voltage code
  input  wire logic [cst_pkg::ADC_W+4:0] out_code,             // output voltage code
  input  wire logic [cst_pkg::ADC_W-1:0] fast_current,         // fast current code
  input  wire logic [cst_pkg::ADC_W-1:0] battery_positive_current,         // battery current code
  input  wire logic                      battery_present,      // battery detected
  input  wire logic                      start_fast,           // fast start request
  input  wire logic                      timeout,              // charge timer expired
  input  wire logic                      hot,                  // above hot_threshold
  output logic                           fast_ff,              // fast charge state
  output logic [cst_pkg::ADC_W-1:0]      target_current_ff,    // current set point
  output logic [cst_pkg::ADC_W+4:0]      volt_cap_ff,          // voltage cap code
  output logic                           drive_down_ff,        // reduce pass_drive_sink
  output logic                           volt_mode_ff,         // voltage regulation only
  output logic                           sampling_ff           // conversion active
);
  // ------------------------------------------------------------
  // slope detector
  // ------------------------------------------------------------
  logic trip;
  logic sampling;
  logic hot_seen_ff;
  logic [2:0] nxt_shift;
  logic [cst_pkg::ADC_W+4:0] nxt_cap;
  logic [cst_pkg::ADC_W-1:0] i_set;

  cst_slope #(.INTERVAL(INTERVAL), .SAMPLE(SAMPLE), .NEG_MODE(NEG_MODE)) u_slope (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (fast_ff),
    .adc_code (battery_positive_code),
    .cells    (cell_count),
    .trip     (trip),
    .sampling (sampling)
  );

  // ------------------------------------------------------------
  // charge state: only fast or trickle
  // ------------------------------------------------------------
  // hot latch keeps fast off until reset, so cooling cannot restart it
  always_ff @(posedge core_clk)
  begin
    if (reset)
      hot_seen_ff <= 1'b0;
    else if (hot)
      hot_seen_ff <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      fast_ff <= 1'b0;
    else if (timeout || trip || hot)
      fast_ff <= 1'b0;
    else if (start_fast && !hot_seen_ff && battery_present)
      fast_ff <= 1'b1;
  end

  // ------------------------------------------------------------
  // regulation set points
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (trickle_ratio_select)
      cst_pkg::TR_SUPPLY: nxt_shift = cst_pkg::SH_SUPPLY;
      cst_pkg::TR_OPEN:   nxt_shift = cst_pkg::SH_OPEN;
      cst_pkg::TR_REF:    nxt_shift = cst_pkg::SH_REF;
      cst_pkg::TR_NEG:    nxt_shift = cst_pkg::SH_NEG;
    endcase
  end

  assign nxt_cap = cst_pkg::ADC_W'(cell_voltage_limit) * 17'(cell_count);
  assign i_set   = fast_ff ? fast_current : (fast_current >> nxt_shift);

  // set points registered so outputs come straight from flops
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      target_current_ff <= '0;
      volt_cap_ff       <= '0;
    end
    else
    begin
      target_current_ff <= i_set;
      volt_cap_ff       <= nxt_cap;
    end
  end

  // ------------------------------------------------------------
  // drive reduction and mode
  // ------------------------------------------------------------
  // without a battery the current loop is ignored; only the cap regulates
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      drive_down_ff <= 1'b1;
      volt_mode_ff  <= 1'b1;
      sampling_ff   <= 1'b0;
    end
    else
    begin
      drive_down_ff <= (out_code > volt_cap_ff) ||
                       (battery_present && (battery_positive_current > target_current_ff));
      volt_mode_ff  <= !battery_present;
      sampling_ff   <= sampling;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_force_trickle;
    @(posedge core_clk) disable iff (reset) (timeout || trip) |=> !fast_ff;
  endproperty
  a_force_trickle: assert property (p_force_trickle) else $error("fast held after timeout or slope");

  property p_hot_no_restart;
    @(posedge core_clk) disable iff (reset) hot_seen_ff |=> !fast_ff;
  endproperty
  a_hot_no_restart: assert property (p_hot_no_restart) else $error("fast after hot");

  property p_overvolt_cut;
    @(posedge core_clk) disable iff (reset) (out_code > volt_cap_ff) |=> drive_down_ff;
  endproperty
  a_overvolt_cut: assert property (p_overvolt_cut) else $error("drive not reduced");

  property p_no_battery_positive_mode;
    @(posedge core_clk) disable iff (reset) !battery_present |=> volt_mode_ff;
  endproperty
  a_no_battery_positive_mode: assert property (p_no_battery_positive_mode) else $error("voltage mode missing");

  property p_trickle_ratio;
    @(posedge core_clk) disable iff (reset)
      (!fast_ff && trickle_ratio_select == cst_pkg::TR_SUPPLY) |=> target_current_ff == ($past(fast_current) >> 6);
  endproperty
  a_trickle_ratio: assert property (p_trickle_ratio) else $error("trickle ratio wrong");

  property p_trickle_open;
    @(posedge core_clk) disable iff (reset)
      (!fast_ff && trickle_ratio_select == cst_pkg::TR_OPEN) |=> target_current_ff == ($past(fast_current) >> 5);
  endproperty
  a_trickle_open: assert property (p_trickle_open) else $error("trickle ratio wrong at open strap");

  property p_trickle_ref;
    @(posedge core_clk) disable iff (reset)
      (!fast_ff && trickle_ratio_select == cst_pkg::TR_REF) |=> target_current_ff == ($past(fast_current) >> 4);
  endproperty
  a_trickle_ref: assert property (p_trickle_ref) else $error("trickle ratio wrong at reference strap");

  property p_trickle_neg;
    @(posedge core_clk) disable iff (reset)
      (!fast_ff && trickle_ratio_select == cst_pkg::TR_NEG) |=> target_current_ff == ($past(fast_current) >> 3);
  endproperty
  a_trickle_neg: assert property (p_trickle_neg) else $error("trickle ratio wrong at negative strap");

  // overcurrent alone must pull the drive back, even with the voltage in range
  property p_overcurrent_cut;
    @(posedge core_clk) disable iff (reset) (battery_present && battery_positive_current > target_current_ff) |=> drive_down_ff;
  endproperty
  a_overcurrent_cut: assert property (p_overcurrent_cut) else $error("drive not reduced on overcurrent");

  property p_drive_release;
    @(posedge core_clk) disable iff (reset)
      (!(out_code > volt_cap_ff) && !(battery_present && battery_positive_current > target_current_ff)) |=> !drive_down_ff;
  endproperty
  a_drive_release: assert property (p_drive_release) else $error("drive held down in range");

  property p_start_fast;
    @(posedge core_clk) disable iff (reset)
      (start_fast && battery_present && !hot_seen_ff && !timeout && !trip && !hot) |=> fast_ff;
  endproperty
  a_start_fast: assert property (p_start_fast) else $error("fast charge not entered");

  property p_hot_cut;
    @(posedge core_clk) disable iff (reset) hot |=> !fast_ff;
  endproperty
  a_hot_cut: assert property (p_hot_cut) else $error("fast held while hot");

  property p_cap;
    @(posedge core_clk) disable iff (reset) 1'b1 |=> volt_cap_ff == 17'($past(cell_voltage_limit)) * 17'($past(cell_count));
  endproperty
  a_cap: assert property (p_cap) else $error("voltage cap wrong");

  property p_idle_trickle;
    @(posedge core_clk) disable iff (reset) !fast_ff |=> !sampling;
  endproperty
  a_idle_trickle: assert property (p_idle_trickle) else $error("sampling in trickle");

  property p_fast_current;
    @(posedge core_clk) disable iff (reset) fast_ff |=> target_current_ff == $past(fast_current);
  endproperty
  a_fast_current: assert property (p_fast_current) else $error("fast set point wrong");
endmodule

// ===== cst_battery_positive_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// battery pack and load model
// ------------------------------------------------------------
module cst_battery_positive_model (
  input  wire logic                      core_clk,        // clock
  input  wire logic                      sampling,        // converter busy
  input  wire logic [cst_pkg::ADC_W-1:0] target,          // current set point
  input  wire logic                      inserted,        // pack in place
  input  wire logic                      over,            // draw one code above set point
  input  wire logic signed [12:0]        step,            // voltage change per sample
  output logic      [cst_pkg::ADC_W-1:0] battery_positive_code,       // pack voltage code
  output logic      [cst_pkg::ADC_W-1:0] battery_positive_current,    // pack current code
  output logic                           battery_present  // pack detected
);
  logic samp_q;

  initial battery_positive_code = 12'h800;
  // voltage moves only after a conversion ends, so no capture sees it mid-change
  always @(posedge core_clk)
  begin
    samp_q <= sampling;
    if (samp_q && !sampling)
      battery_positive_code <= battery_positive_code + step[11:0];
  end
  // pack current follows the regulated set point; nothing flows without a pack
  assign battery_present = inserted;
  assign battery_positive_current    = inserted ? target + {11'h0, over} : 12'h0;
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  localparam longint INTV = 50;  // shortened slope interval
  localparam longint SAMP = 10;  // shortened conversion time
  localparam int     CYC  = int'(2 * (INTV + SAMP));
  logic               core_clk = 1'b0;
  logic               reset    = 1'b1;
  logic [1:0]         sel      = 2'h0;
  logic [1:0]         strap    = 2'h0;
  logic [4:0]         cells    = 5'h4;
  logic [11:0]        lim      = 12'h3e8;
  logic [11:0]        fc       = 12'h400;
  logic [16:0]        out_code = 17'h0;
  logic               inserted = 1'b1;
  logic               over     = 1'b0;
  logic               start    = 1'b0;
  logic               tmo      = 1'b0;
  logic               hot      = 1'b0;
  logic signed [12:0] step     = 13'h0;
  logic [11:0]        bcode, bcur, tgt;
  logic [16:0]        cap;
  logic               present, fast, drv, vmode, samp;
  logic               fast_z;
  logic               samp_prev  = 1'b0;
  int                 smp_q[$];
  int                 n_mismatch = 0;
  int                 compares   = 0;
  int                 cyc, hi, ecap;

  // free-running core clock
  always #25 core_clk = ~core_clk;

  cst_top #(.INTERVAL(INTV), .SAMPLE(SAMP), .NEG_MODE(1'b1)) u_dut (
    .core_clk(core_clk), .reset(reset), .trickle_ratio_select(sel), .cell_count_select_lo(strap[0]),
    .cell_count_select_hi(strap[1]), .cell_count(cells), .cell_voltage_limit(lim), .battery_positive_code(bcode),
    .out_code(out_code), .fast_current(fc), .battery_positive_current(bcur), .battery_present(present),
    .start_fast(start), .timeout(tmo), .hot(hot), .fast_ff(fast), .target_current_ff(tgt),
    .volt_cap_ff(cap), .drive_down_ff(drv), .volt_mode_ff(vmode), .sampling_ff(samp));

  cst_battery_positive_model u_battery_positive (.core_clk(core_clk), .sampling(samp), .target(tgt), .inserted(inserted),
    .over(over), .step(step), .battery_positive_code(bcode), .battery_positive_current(bcur), .battery_present(present));

  // zero-slope variant on the same pack, only its charge state is watched
  cst_top #(.INTERVAL(INTV), .SAMPLE(SAMP), .NEG_MODE(1'b0)) u_dut_zero (
    .core_clk(core_clk), .reset(reset), .trickle_ratio_select(sel), .cell_count_select_lo(strap[0]),
    .cell_count_select_hi(strap[1]), .cell_count(cells), .cell_voltage_limit(lim), .battery_positive_code(bcode),
    .out_code(out_code), .fast_current(fc), .battery_positive_current(bcur), .battery_present(present),
    .start_fast(start), .timeout(tmo), .hot(hot), .fast_ff(fast_z), .target_current_ff(),
    .volt_cap_ff(), .drive_down_ff(), .volt_mode_ff(), .sampling_ff());

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  // pairs the two conversions of a cycle and predicts the negative-slope verdict
  always @(negedge core_clk)
  begin
    samp_prev <= samp;
    if (start)
      smp_q.delete();
    if (samp_prev && !samp)
    begin
      smp_q.push_back(int'(bcode));
      if (smp_q.size() == 2)
      begin
        `CHK(fast, ((smp_q[0] - smp_q[1]) < int'(cells)))
        smp_q.delete();
      end
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // outputs are read mid-cycle, clear of the edge updates
  task automatic look;
    @(negedge core_clk);
  endtask
  // start fast charge, then count cycles and converter-busy cycles until it ends or n cycles pass
  task automatic slope(input int n, output int c, output int h);
    c = 0;
    h = 0;
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(2);
    look;
    `CHK(fast, 1'b1)
    `CHK(tgt, fc)
    while (fast === 1'b1 && c < n)
    begin
      h += int'(samp === 1'b1);
      tick(1);
      look;
      c++;
    end
  endtask
  task automatic summarize;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog, far beyond the expected run of about 720 cycles
  // ------------------------------------------------------------
  initial
  begin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h336107e5));
    tick(7);
    look;
    `CHK(fast, 1'b0)
    `CHK(drv, 1'b1)
    `CHK(vmode, 1'b1)
    `CHK(samp, 1'b0)
    tick(1);
    reset <= 1'b0;
    // every ratio strap with random pack setup, trickle state
    for (int s = 0; s < 4; s++)
    begin
      sel   <= s[1:0];
      cells <= 5'($urandom_range(16, 1));
      lim   <= 12'($urandom_range(999, 760));
      fc    <= 12'($urandom_range(4095, 64));
      strap <= 2'($urandom());
      tick(1);
      ecap = cells * lim;
      out_code <= 17'(ecap);
      tick(4);
      look;
      `CHK(tgt, 12'(fc >> (6 - s)))
      `CHK(cap, 17'(ecap))
      `CHK(drv, 1'b0)
      `CHK(vmode, 1'b0)
      tick(1);
      out_code <= 17'(ecap + 1);
      tick(4);
      look;
      `CHK(drv, 1'b1)
      tick(1);
      out_code <= 17'(ecap);
      over     <= 1'b1;
      tick(4);
      look;
      `CHK(drv, 1'b1)
      tick(1);
      over <= 1'b0;
    end
    // drop of exactly one code per cell ends the first cycle
    step <= -13'(cells);
    tick(1);
    slope(CYC + 20, cyc, hi);
    `CHK(fast, 1'b0)
    `CHK(cyc >= CYC - 2 && cyc <= CYC + 6, 1'b1)
    `CHK(hi, int'(2 * SAMP))
    `CHK(fast_z, 1'b1)
    // one code short of the trip level keeps cycling
    tick(1);
    step <= -13'(cells - 1);
    tick(1);
    slope(2 * CYC + 10, cyc, hi);
    `CHK(fast, 1'b1)
    `CHK(hi, int'(4 * SAMP))
    tick(1);
    tmo <= 1'b1;
    tick(2);
    look;
    `CHK(fast, 1'b0)
    tick(1);
    tmo <= 1'b0;
    hi = 0;
    repeat (CYC)
    begin
      look;
      hi += int'(samp === 1'b1);
      tick(1);
    end
    `CHK(hi, 0)
    // unchanged voltage ends fast charge in the zero-slope variant only
    step <= 13'h0;
    slope(CYC + 4, cyc, hi);
    `CHK(fast, 1'b1)
    `CHK(fast_z, 1'b0)
    tick(1);
    // hot ends fast charge and locks out restarts
    slope(3, cyc, hi);
    tick(1);
    hot <= 1'b1;
    tick(1);
    hot <= 1'b0;
    tick(2);
    look;
    `CHK(fast, 1'b0)
    tick(1);
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(2);
    look;
    `CHK(fast, 1'b0)
    tick(1);
    inserted <= 1'b0;
    tick(4);
    look;
    `CHK(vmode, 1'b1)
    summarize();
  end
endmodule
